// >>> host_port_pkg.sv
// Shared constants, types and carriers for the coprocessor system-bus port
package host_port_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CFG_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_PORT_WORD_OFS = 8'h08;
  localparam logic [7:0] REG_LAST_PTR_OFS = 8'h0C;

  // Configuration register fields and reset value
  localparam int unsigned CFG_ENH_BIG_ENDIAN_BIT = 7;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Status register fields
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_PAR_ERR_BIT = 1;
  localparam int unsigned ST_PORT_BAD_BIT = 2;
  localparam int unsigned ST_HALF_WIDTH_BIT = 3;

  // Port command strobes per access and low-nibble command codes
  localparam logic PORT_LAST_STROBE = 1'b1;
  localparam logic [3:0] PORT_NIB_RESET = 4'h0;
  localparam logic [3:0] PORT_NIB_SELFTEST = 4'h1;
  localparam logic [3:0] PORT_NIB_RELOCATE = 4'h2;
  localparam logic [3:0] PORT_NIB_DUMP = 4'h3;

  // Width of the asynchronous pin bundle passed through the synchroniser
  localparam int unsigned SYNC_W = 41;
  // Idle pin levels during reset, so no false strobe edge follows it
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 41'hF0_0000_0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DATA1 = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_DONE = 5'b10000
  } bus_state_t;

  typedef enum logic [1:0] {
    PCMD_RESET = 2'b00,
    PCMD_SELFTEST = 2'b01,
    PCMD_RELOCATE = 2'b10,
    PCMD_DUMP = 2'b11
  } port_cmd_kind_t;

  // Memory request from the internal DMA side; be is active high
  typedef struct packed {
    logic write;
    logic ptr32;
    logic [29:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } mem_req_t;

  // Decoded CPU port command
  typedef struct packed {
    logic valid;
    port_cmd_kind_t kind;
    logic [27:0] addr;
  } port_cmd_t;

endpackage : host_port_pkg

// >>> lane_parity.sv
// Per-lane even parity generation and masked parity checking
`timescale 1ns/100ps
`default_nettype none
module lane_parity (
  input wire logic [31:0] data,
  input wire logic [3:0] par_in,
  input wire logic [3:0] lane_mask,
  output logic [3:0] par_gen,
  output logic err
);

  logic [3:0] lane_bad;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      // Parity bit makes byte plus bit an even count of ones
      assign par_gen[g] = ^data[8*g +: 8];
      // Disabled lanes never flag an error
      assign lane_bad[g] = lane_mask[g] & (par_in[g] ^ par_gen[g]);
    end
  endgenerate

  assign err = |lane_bad;

endmodule : lane_parity
`default_nettype wire

// >>> host_bus_port.sv
// System-bus master port with CPU port-command capture and parity handling
//
// Behaviour
// - All logic runs on pclk at 1X, rising edge only.
// - Data bus is 16 or 32 bits wide, chosen per access by bus-size pin.
// - Memory writes drive all 32 data lines, even on a 16-bit bus.
// - Data lines float after reset and while the bus is not owned.
// - During port access data lines are inputs carrying the next address word.
// - Low nibble decodes reset, relocate pointer, self-test or dump; bits 3:2 zero.
// - Writes drive one even parity bit per lane with the data.
// - Parity flag driven one clock after read ready, low on error.
// - Only lanes enabled by byte enables and bus size are checked.
// - Parity flag valid one clock after read data, high otherwise.
// - Thirty word-address lines driven for memory cycles, floated otherwise.
// - Four active-low byte enables map lanes 0..3; float when not owned.
// - Write/read indicator driven during cycles, floated otherwise.
// - Enhanced big-endian: true 32-bit pointers; split items stay two 16-bit halves.
// - Enhanced bit clear: legacy big-endian, software swaps pointer halves.
// - Half-width bus splits transfers touching both halves in two; lower half little, upper half big endian.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module host_bus_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire host_port_pkg::mem_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output host_port_pkg::port_cmd_t port_cmd,
  input wire logic bus_grant,
  input wire logic half_width_select_n,
  input wire logic endian_select,
  input wire logic ready_n,
  input wire logic port_strobe_n,
  input wire logic [31:0] data_lines_i,
  output logic [31:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [3:0] lane_parity_i,
  output logic [3:0] lane_parity_o,
  output logic lane_parity_oe,
  output logic [29:0] word_address_lines_o,
  output logic word_address_lines_oe,
  output logic [3:0] byte_lane_enable_n_o,
  output logic byte_lane_enable_n_oe,
  output logic write_read_o,
  output logic write_read_oe,
  output logic parity_error_flag_n
);

  // Lanes of one access: whole word, or one 16-bit half of it
  function automatic logic [3:0] access_lanes(input logic [3:0] be, input logic half, input logic upper);
    access_lanes = !half ? be : upper ? {be[3:2], 2'b00} : {2'b00, be[1:0]};
  endfunction : access_lanes

  // Lanes a half-width bus carries: low pair little, high pair big endian
  function automatic logic [3:0] phys_lanes(input logic [3:0] lanes, input logic half, input logic little);
    logic [1:0] pair;
    pair = lanes[3:2] | lanes[1:0];
    phys_lanes = !half ? lanes : little ? {2'b00, pair} : {pair, 2'b00};
  endfunction : phys_lanes

  // Pointer view of a memory word under the byte-order settings
  function automatic logic [31:0] to_pointer(input logic [31:0] w, input logic little, input logic enh,
                                             input logic ptr32);
    to_pointer = little ? w : (enh && ptr32) ? {w[7:0], w[15:8], w[23:16], w[31:24]} :
                 {w[23:16], w[31:24], w[7:0], w[15:8]};
  endfunction : to_pointer

  // Two-stage synchroniser for every pin input
  logic [host_port_pkg::SYNC_W-1:0] sync1_q;
  logic [host_port_pkg::SYNC_W-1:0] sync2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= host_port_pkg::SYNC_IDLE;
      sync2_q <= host_port_pkg::SYNC_IDLE;
    end else begin
      sync1_q <= {bus_grant, half_width_select_n, endian_select, ready_n, port_strobe_n,
                  data_lines_i, lane_parity_i};
      sync2_q <= sync1_q;
    end
  end

  logic grant_s, half_n_s, little_s, ready_n_s, strobe_n_s;
  logic [31:0] data_s;
  logic [3:0] par_s;

  assign {grant_s, half_n_s, little_s, ready_n_s, strobe_n_s, data_s, par_s} = sync2_q;

  // Configuration and status
  logic [31:0] cfg_q, port_word_q, last_ptr_q;
  logic par_err_sticky_q, port_bad_sticky_q, enh_be;

  assign enh_be = cfg_q[host_port_pkg::CFG_ENH_BIG_ENDIAN_BIT];

  // Bus cycle sequencer
  host_port_pkg::bus_state_t state_q;
  host_port_pkg::mem_req_t cur_q;
  logic half_q, little_q, upper_q, need_upper_q, rd_err, start;
  logic [31:0] rdata_q, wdrive;
  logic [3:0] lanes, chk_mask, wpar;
  logic [15:0] whalf;

  assign lanes = access_lanes(cur_q.be, half_q, upper_q);
  assign chk_mask = phys_lanes(lanes, half_q, little_q);
  assign whalf = upper_q ? cur_q.wdata[31:16] : cur_q.wdata[15:0];
  // Active half on both halves, so all 32 lines carry data
  assign wdrive = half_q ? {whalf, whalf} : cur_q.wdata;
  assign start = (state_q == host_port_pkg::ST_IDLE) && req_valid && req_ready;

  lane_parity u_wr_par (
    .data(wdrive),
    .par_in(4'h0),
    .lane_mask(4'h0),
    .par_gen(wpar),
    .err()
  );

  lane_parity u_rd_par (
    .data(data_s),
    .par_in(par_s),
    .lane_mask(chk_mask),
    .par_gen(),
    .err(rd_err)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= host_port_pkg::ST_IDLE;
      cur_q <= '0;
      half_q <= 1'b0;
      little_q <= 1'b1;
      upper_q <= 1'b0;
      need_upper_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        host_port_pkg::ST_IDLE: begin
          if (start) begin
            cur_q <= req;
            // Bus size and byte order are taken per access
            half_q <= !half_n_s;
            little_q <= little_s;
            upper_q <= !half_n_s && (req.be[1:0] == 2'b00);
            need_upper_q <= !half_n_s && (req.be[1:0] != 2'b00) && (req.be[3:2] != 2'b00);
            rdata_q <= 32'h0000_0000;
            state_q <= host_port_pkg::ST_ADDR;
          end
        end
        host_port_pkg::ST_ADDR: begin
          state_q <= host_port_pkg::ST_DATA1;
        end
        host_port_pkg::ST_DATA1: begin
          // Ready is not looked at in the first data clock
          state_q <= host_port_pkg::ST_WAIT;
        end
        host_port_pkg::ST_WAIT: begin
          if (!ready_n_s) begin
            if (!half_q) begin
              rdata_q <= data_s;
            end else if (upper_q) begin
              rdata_q[31:16] <= little_q ? data_s[15:0] : data_s[31:16];
            end else begin
              rdata_q[15:0] <= little_q ? data_s[15:0] : data_s[31:16];
            end
            if (need_upper_q) begin
              need_upper_q <= 1'b0;
              upper_q <= 1'b1;
              state_q <= host_port_pkg::ST_ADDR;
            end else begin
              state_q <= host_port_pkg::ST_DONE;
            end
          end
        end
        host_port_pkg::ST_DONE: begin
          state_q <= host_port_pkg::ST_IDLE;
        end
        default: begin
          state_q <= host_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers; enables also drop three clocks after the grant is lost (two sync stages plus output register)
  logic active, drive_wr;

  assign active = (state_q == host_port_pkg::ST_ADDR) || (state_q == host_port_pkg::ST_DATA1) ||
                  (state_q == host_port_pkg::ST_WAIT);
  assign drive_wr = active && cur_q.write && grant_s && strobe_n_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_address_lines_o <= '0;
      word_address_lines_oe <= 1'b0;
      byte_lane_enable_n_o <= 4'hF;
      byte_lane_enable_n_oe <= 1'b0;
      write_read_o <= 1'b0;
      write_read_oe <= 1'b0;
      data_lines_o <= 32'h0000_0000;
      data_lines_oe <= 1'b0;
      lane_parity_o <= 4'h0;
      lane_parity_oe <= 1'b0;
    end else begin
      word_address_lines_o <= cur_q.addr;
      word_address_lines_oe <= active && grant_s;
      byte_lane_enable_n_o <= ~lanes;
      byte_lane_enable_n_oe <= active && grant_s;
      write_read_o <= cur_q.write;
      write_read_oe <= active && grant_s;
      data_lines_o <= wdrive;
      // Never drive while not owning the bus or while the CPU writes a port word
      data_lines_oe <= drive_wr;
      lane_parity_o <= wpar;
      lane_parity_oe <= drive_wr;
    end
  end

  // Parity flag: low for the single clock after a failing read ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_error_flag_n <= 1'b1;
    end else if (state_q == host_port_pkg::ST_WAIT && !ready_n_s && !cur_q.write) begin
      parity_error_flag_n <= !rd_err;
    end else begin
      parity_error_flag_n <= 1'b1;
    end
  end

  // Internal request handshake and response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
      last_ptr_q <= 32'h0000_0000;
    end else begin
      req_ready <= (state_q == host_port_pkg::ST_IDLE) && !start && grant_s && strobe_n_s;
      rsp_valid <= (state_q == host_port_pkg::ST_DONE);
      if (state_q == host_port_pkg::ST_DONE && !cur_q.write) begin
        rsp_rdata <= to_pointer(rdata_q, little_q, enh_be, cur_q.ptr32);
        last_ptr_q <= to_pointer(rdata_q, little_q, enh_be, cur_q.ptr32);
      end
    end
  end

  // CPU port access: two strobes per command, data latched on each
  logic strobe_d_q, second_q, strobe_fall, port_bad_set;
  logic [15:0] first_low_q;
  logic [31:0] port_full;

  assign strobe_fall = strobe_d_q && !strobe_n_s;
  assign port_full = !half_n_s ? {data_s[15:0], first_low_q} : data_s;
  assign port_bad_set = strobe_fall && second_q && (port_full[3:2] != 2'b00 ||
                        (port_full[3:0] == host_port_pkg::PORT_NIB_RESET && port_full[31:4] != 28'h000_0000));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_d_q <= 1'b1;
      second_q <= 1'b0;
      first_low_q <= 16'h0000;
      port_word_q <= 32'h0000_0000;
      port_cmd <= '0;
    end else begin
      strobe_d_q <= strobe_n_s;
      port_cmd.valid <= 1'b0;
      if (strobe_fall) begin
        port_word_q <= data_s;
        second_q <= !second_q;
        if (!second_q) begin
          first_low_q <= data_s[15:0];
        end else if (!port_bad_set) begin
          // Address occupies bits 31:4; low nibble is the command
          port_cmd.valid <= 1'b1;
          port_cmd.addr <= port_full[31:4];
          case (port_full[3:0])
            host_port_pkg::PORT_NIB_SELFTEST: port_cmd.kind <= host_port_pkg::PCMD_SELFTEST;
            host_port_pkg::PORT_NIB_RELOCATE: port_cmd.kind <= host_port_pkg::PCMD_RELOCATE;
            host_port_pkg::PORT_NIB_DUMP: port_cmd.kind <= host_port_pkg::PCMD_DUMP;
            default: port_cmd.kind <= host_port_pkg::PCMD_RESET;
          endcase
        end
      end
    end
  end

  // APB slave: one wait state, so every bus output comes from a register
  logic apb_access, apb_commit, mapped;
  logic [31:0] rd_mux, status;

  assign apb_access = psel && penable && !pready;
  assign apb_commit = psel && penable && pready;
  assign mapped = (paddr == host_port_pkg::REG_CFG_OFS) || (paddr == host_port_pkg::REG_STATUS_OFS) ||
                  (paddr == host_port_pkg::REG_PORT_WORD_OFS) || (paddr == host_port_pkg::REG_LAST_PTR_OFS);

  always_comb begin
    status = 32'h0000_0000;
    status[host_port_pkg::ST_BUSY_BIT] = (state_q != host_port_pkg::ST_IDLE);
    status[host_port_pkg::ST_PAR_ERR_BIT] = par_err_sticky_q;
    status[host_port_pkg::ST_PORT_BAD_BIT] = port_bad_sticky_q;
    status[host_port_pkg::ST_HALF_WIDTH_BIT] = half_q;
    case (paddr)
      host_port_pkg::REG_CFG_OFS: rd_mux = cfg_q;
      host_port_pkg::REG_STATUS_OFS: rd_mux = status;
      host_port_pkg::REG_PORT_WORD_OFS: rd_mux = port_word_q;
      host_port_pkg::REG_LAST_PTR_OFS: rd_mux = last_ptr_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access;
      prdata <= (apb_access && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= apb_access && !mapped;
    end
  end

  // Only bit 7 of the configuration is implemented; others read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= host_port_pkg::CFG_RESET;
    end else if (apb_commit && pwrite && paddr == host_port_pkg::REG_CFG_OFS) begin
      cfg_q <= 32'h0000_0000;
      cfg_q[host_port_pkg::CFG_ENH_BIG_ENDIAN_BIT] <= pwdata[host_port_pkg::CFG_ENH_BIG_ENDIAN_BIT];
    end
  end

  // Sticky flags: write one to clear, a new event in the same cycle wins
  logic st_wr;

  assign st_wr = apb_commit && pwrite && paddr == host_port_pkg::REG_STATUS_OFS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_err_sticky_q <= 1'b0;
      port_bad_sticky_q <= 1'b0;
    end else begin
      par_err_sticky_q <= (par_err_sticky_q && !(st_wr && pwdata[host_port_pkg::ST_PAR_ERR_BIT])) ||
                          (state_q == host_port_pkg::ST_WAIT && !ready_n_s && !cur_q.write && rd_err);
      port_bad_sticky_q <= (port_bad_sticky_q && !(st_wr && pwdata[host_port_pkg::ST_PORT_BAD_BIT])) ||
                           port_bad_set;
    end
  end

endmodule : host_bus_port
`default_nettype wire

// >>> host_bus_port_checker.sv
// Concurrent checks on the system-bus port pins
`timescale 1ns/100ps
`default_nettype none
module host_bus_port_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_grant,
  input wire logic rsp_valid,
  input wire host_port_pkg::port_cmd_t port_cmd,
  input wire logic [31:0] data_lines_o,
  input wire logic data_lines_oe,
  input wire logic [3:0] lane_parity_o,
  input wire logic lane_parity_oe,
  input wire logic word_address_lines_oe,
  input wire logic [3:0] byte_lane_enable_n_o,
  input wire logic byte_lane_enable_n_oe,
  input wire logic write_read_o,
  input wire logic write_read_oe,
  input wire logic parity_error_flag_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence flag_pulse;
    !parity_error_flag_n ##1 parity_error_flag_n;
  endsequence
  chk_flag_one_clock: assert property ($fell(parity_error_flag_n) |-> flag_pulse)
    else $error("parity flag low for more than one clock");
  chk_flag_after_read: assert property ($fell(parity_error_flag_n) |-> ##[0:3] rsp_valid)
    else $error("parity flag low outside a read completion");
  chk_parity_oe: assert property (lane_parity_oe == data_lines_oe)
    else $error("parity pins not driven with write data only");
  chk_parity_even: assert property (lane_parity_oe |-> lane_parity_o == {^data_lines_o[31:24],
    ^data_lines_o[23:16], ^data_lines_o[15:8], ^data_lines_o[7:0]})
    else $error("write parity not even per lane");
  chk_data_on_write: assert property (data_lines_oe |-> write_read_oe && write_read_o)
    else $error("data lines driven outside a write");
  chk_cycle_oe_group: assert property (word_address_lines_oe == byte_lane_enable_n_oe
    && byte_lane_enable_n_oe == write_read_oe)
    else $error("address, lane enable and direction drive differ");
  chk_lane_some: assert property (byte_lane_enable_n_oe |-> byte_lane_enable_n_o != 4'hf)
    else $error("bus cycle with no lane enabled");
  chk_grant_float: assert property (!bus_grant [*4] |-> !word_address_lines_oe && !data_lines_oe)
    else $error("pins driven while bus not owned");
  chk_cmd_pulse: assert property (port_cmd.valid |=> !port_cmd.valid)
    else $error("port command valid longer than one clock");
endmodule : host_bus_port_checker
bind host_bus_port host_bus_port_checker u_chk (.pclk, .presetn, .bus_grant, .rsp_valid, .port_cmd,
  .data_lines_o, .data_lines_oe, .lane_parity_o, .lane_parity_oe, .word_address_lines_oe,
  .byte_lane_enable_n_o, .byte_lane_enable_n_oe, .write_read_o, .write_read_oe, .parity_error_flag_n);
`default_nettype wire

// >>> mem_model.sv
// Behavioural shared memory and CPU port driver on the far side of the bus
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] waits,
  input wire logic [3:0] bad_par,
  input wire logic half_n,
  input wire logic port_en,
  input wire logic [31:0] port_word,
  input wire logic [31:0] dout,
  input wire logic [29:0] addr,
  input wire logic addr_oe,
  input wire logic [3:0] be_n,
  input wire logic wr,
  output logic ready_n,
  output logic [31:0] din,
  output logic [3:0] par
);
  logic [31:0] mem [16];
  logic [31:0] last_q;
  logic [33:0] key_q;
  logic [3:0] cnt_q;
  logic [31:0] w;
  logic hit;
  assign w = mem[addr[3:0]];
  assign hit = addr_oe && {be_n, addr} == key_q;
  // Undriven lines show the inverse of the last value so stale data cannot pass
  always_comb begin
    if (port_en) din = port_word;
    else if (addr_oe && !wr && half_n) din = w;
    else if (addr_oe && !wr) din = be_n[3:2] != 2'b11 ? {2{w[31:16]}} : {2{w[15:0]}};
    else din = ~last_q;
  end
  assign par = {^din[31:24], ^din[23:16], ^din[15:8], ^din[7:0]} ^ bad_par;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= '0;
      cnt_q <= '0;
      ready_n <= 1'b1;
      last_q <= '0;
    end else begin
      key_q <= {be_n, addr};
      last_q <= din;
      cnt_q <= hit ? cnt_q + 4'h1 : 4'h0;
      ready_n <= !(hit && cnt_q == waits);
    end
  end
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++)
      if (hit && cnt_q == waits && wr && !be_n[i]) mem[addr[3:0]][8*i +: 8] <= dout[8*i +: 8];
  end
endmodule : mem_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the system-bus port
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_ready, rsp_valid;
  logic bus_grant, half_width_select_n, endian_select, ready_n, port_strobe_n, port_en;
  logic data_lines_oe, lane_parity_oe, word_address_lines_oe, byte_lane_enable_n_oe;
  logic write_read_o, write_read_oe, parity_error_flag_n, oe_d, seen_wr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rsp_rdata, data_lines_i, data_lines_o, port_word, r;
  logic [3:0] lane_parity_i, lane_parity_o, byte_lane_enable_n_o, bad_par, waits, be_d, seen_be;
  logic [29:0] word_address_lines_o, seen_a;
  logic e;
  host_port_pkg::mem_req_t req;
  host_port_pkg::port_cmd_t port_cmd, pc_q;
  int miscompares, cmp_count, flag_lows, acc_n, pc_n;
  host_bus_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .req_valid, .req, .req_ready, .rsp_valid, .rsp_rdata, .port_cmd, .bus_grant,
    .half_width_select_n, .endian_select, .ready_n, .port_strobe_n, .data_lines_i, .data_lines_o,
    .data_lines_oe, .lane_parity_i, .lane_parity_o, .lane_parity_oe, .word_address_lines_o,
    .word_address_lines_oe, .byte_lane_enable_n_o, .byte_lane_enable_n_oe, .write_read_o,
    .write_read_oe, .parity_error_flag_n);
  mem_model u_mem (.pclk, .presetn, .waits, .bad_par, .half_n(half_width_select_n), .port_en,
    .port_word, .dout(data_lines_o), .addr(word_address_lines_o), .addr_oe(word_address_lines_oe),
    .be_n(byte_lane_enable_n_o), .wr(write_read_o), .ready_n, .din(data_lines_i), .par(lane_parity_i));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Split halves show up as a change of lane enables while the cycle stays driven
  always @(posedge pclk) begin
    oe_d <= word_address_lines_oe;
    be_d <= byte_lane_enable_n_o;
    if (word_address_lines_oe === 1'b1 && (!oe_d || byte_lane_enable_n_o != be_d)) acc_n <= acc_n + 1;
    if (word_address_lines_oe === 1'b1) {seen_wr, seen_be, seen_a} <= {write_read_o,
      byte_lane_enable_n_o, word_address_lines_o};
    if (parity_error_flag_n === 1'b0) flag_lows <= flag_lows + 1;
    if (port_cmd.valid === 1'b1) pc_q <= port_cmd;
    if (port_cmd.valid === 1'b1) pc_n <= pc_n + 1;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : chk
  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      stop_test();
    end
  endtask : hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    hang(n, 20);
    @(posedge pclk);
  endtask : apb
  task automatic mem_op(input logic w, p, input logic [29:0] a, input logic [3:0] b, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{write: w, ptr32: p, addr: a, be: b, wdata: d};
    req_valid <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    hang(n, 50);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 60);
    hang(n, 60);
  endtask : mem_op
  task automatic strobe(input logic [31:0] w);
    port_word <= w;
    repeat (2) @(posedge pclk);
    port_strobe_n <= 1'b0;
    repeat (3) @(posedge pclk);
    port_strobe_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : strobe
  task automatic t_regs();
    apb(1'b0, host_port_pkg::REG_CFG_OFS, 32'h0);
    chk("cfg reset", r, host_port_pkg::CFG_RESET);
    apb(1'b1, host_port_pkg::REG_CFG_OFS, 32'h0000_0080);
    apb(1'b0, host_port_pkg::REG_CFG_OFS, 32'h0);
    chk("cfg", r, 32'h0000_0080);
    apb(1'b1, host_port_pkg::REG_CFG_OFS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask : t_regs
  task automatic t_wr();
    u_mem.mem[4] = 32'h0;
    waits <= 4'h5;
    mem_op(1'b1, 1'b0, 30'h3, 4'hf, 32'hc3a5_5a3c);
    chk("mem full", u_mem.mem[3], 32'hc3a5_5a3c);
    chk("addr", {2'b0, seen_a}, 32'h3);
    chk("dir", {31'h0, seen_wr}, 32'h1);
    waits <= 4'h0;
    mem_op(1'b1, 1'b0, 30'h4, 4'h6, 32'h1234_5678);
    chk("lanes", {28'h0, seen_be}, 32'h9);
    chk("mem part", u_mem.mem[4], 32'h0034_5600);
  endtask : t_wr
  task automatic t_par();
    int f;
    u_mem.mem[6] = 32'h8001_0203;
    bad_par <= 4'h8;
    f = flag_lows;
    mem_op(1'b0, 1'b0, 30'h6, 4'h3, 32'h0);
    repeat (3) @(posedge pclk);
    chk("masked lane", 32'(flag_lows - f), 32'h0);
    chk("rd low", {16'h0, rsp_rdata[15:0]}, 32'h0203);
    bad_par <= 4'h1;
    mem_op(1'b0, 1'b0, 30'h6, 4'h1, 32'h0);
    repeat (3) @(posedge pclk);
    chk("par flag", 32'(flag_lows - f), 32'h1);
    apb(1'b0, host_port_pkg::REG_STATUS_OFS, 32'h0);
    chk("par status", {31'h0, r[host_port_pkg::ST_PAR_ERR_BIT]}, 32'h1);
    bad_par <= 4'h0;
  endtask : t_par
  task automatic t_half();
    int a;
    half_width_select_n <= 1'b0;
    repeat (3) @(posedge pclk);
    a = acc_n;
    mem_op(1'b1, 1'b0, 30'h5, 4'hf, 32'ha5a5_0ff0);
    chk("half mem", u_mem.mem[5], 32'ha5a5_0ff0);
    chk("half count", 32'(acc_n - a), 32'h2);
    mem_op(1'b0, 1'b0, 30'h5, 4'hf, 32'h0);
    chk("half rd", rsp_rdata, 32'ha5a5_0ff0);
    half_width_select_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : t_half
  task automatic t_endian();
    logic [31:0] exp [3] = '{32'h4433_2211, 32'h2211_4433, 32'h2211_4433};
    endian_select <= 1'b0;
    u_mem.mem[2] = 32'h1122_3344;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, host_port_pkg::REG_CFG_OFS, i < 2 ? 32'h0000_0080 : 32'h0);
      mem_op(1'b0, i != 1, 30'h2, 4'hf, 32'h0);
      chk("ptr order", rsp_rdata, exp[i]);
    end
    endian_select <= 1'b1;
  endtask : t_endian
  task automatic t_port();
    host_port_pkg::port_cmd_kind_t k [4] = '{host_port_pkg::PCMD_RESET, host_port_pkg::PCMD_SELFTEST,
      host_port_pkg::PCMD_RELOCATE, host_port_pkg::PCMD_DUMP};
    logic [31:0] w;
    int n;
    bus_grant <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("float", {31'h0, data_lines_oe | word_address_lines_oe}, 32'h0);
    port_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      w = i == 0 ? 32'h0 : i < 4 ? {28'h0ab_cde1, 4'(i)} : i == 4 ? 32'h0ab_cde4 : 32'h0000_0010;
      n = pc_n;
      strobe(w);
      strobe(w);
      repeat (6) @(posedge pclk);
      chk("cmd count", 32'(pc_n - n), i < 4 ? 32'h1 : 32'h0);
      if (i < 4) chk("cmd kind", {30'h0, pc_q.kind}, {30'h0, k[i]});
      if (i < 4) chk("cmd addr", {4'h0, pc_q.addr}, w >> 4);
    end
    apb(1'b0, host_port_pkg::REG_STATUS_OFS, 32'h0);
    chk("bad cmd", {31'h0, r[host_port_pkg::ST_PORT_BAD_BIT]}, 32'h1);
    port_en <= 1'b0;
    bus_grant <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : t_port
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_valid = 1'b0;
    req = '0;
    bus_grant = 1'b1;
    half_width_select_n = 1'b1;
    endian_select = 1'b1;
    port_strobe_n = 1'b1;
    port_en = 1'b0;
    port_word = 32'h0;
    bad_par = 4'h0;
    waits = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_wr();
    t_par();
    t_half();
    t_endian();
    t_port();
    stop_test();
  end
endmodule : tb
`default_nettype wire
